// file: include/ffpsm_pkg.sv
// Shared constants for the fast-forcing / protect / spurious / mask interrupt block.
// Assumes a 12-bit byte address space and 32-bit data on the register bus.
package ffpsm_pkg;
	// Widths of the register bus.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Default number of sources and depth of the priority stack.
	localparam int NUM_SRC     = 32;
	localparam int STACK_DEPTH = 8;
	// Register byte offsets.
	localparam logic [11:0] OFS_MODE_BASE   = 12'h000;
	localparam logic [11:0] OFS_VECTOR_BASE = 12'h080;
	localparam logic [11:0] OFS_NORMAL_VEC  = 12'h100;
	localparam logic [11:0] OFS_FAST_VEC    = 12'h104;
	localparam logic [11:0] OFS_CUR_STATUS  = 12'h108;
	localparam logic [11:0] OFS_PENDING     = 12'h10c;
	localparam logic [11:0] OFS_MASK        = 12'h110;
	localparam logic [11:0] OFS_CORE_STATUS = 12'h114;
	localparam logic [11:0] OFS_ENABLE_CMD  = 12'h120;
	localparam logic [11:0] OFS_DISABLE_CMD = 12'h124;
	localparam logic [11:0] OFS_CLEAR_CMD   = 12'h128;
	localparam logic [11:0] OFS_SET_CMD     = 12'h12c;
	localparam logic [11:0] OFS_END_OF_INT  = 12'h130;
	localparam logic [11:0] OFS_SPURIOUS    = 12'h134;
	localparam logic [11:0] OFS_DEBUG_CTRL  = 12'h138;
	localparam logic [11:0] OFS_FORCE_EN    = 12'h140;
	localparam logic [11:0] OFS_FORCE_DIS   = 12'h144;
	localparam logic [11:0] OFS_FORCE_STAT  = 12'h148;
	// Field positions.
	localparam int MODE_PRIO_LSB   = 0;
	localparam int MODE_TYPE_LSB   = 5;
	localparam int TYPE_EDGE_BIT   = 0;
	localparam int TYPE_HIGH_BIT   = 1;
	localparam int DBG_PROTECT_BIT = 0;
	localparam int DBG_GMASK_BIT   = 1;
	localparam int CORE_FAST_BIT   = 0;
	localparam int CORE_NORMAL_BIT = 1;
	// Values after reset.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// file: include/ffpsm_if.sv
// Interface joining the interrupt controller and the core that it serves.
// Assumes one shared clock; the core is the register-bus master.
`timescale 1ns/1ps
interface ffpsm_if;
	// Register bus.
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Request lines, active low, and the idle wake-up level.
	logic        fast_request_n;
	logic        normal_request_n;
	logic        wakeUp;
	// Controller end.
	modport device (input psel, penable, pwrite, paddr, pwdata,
		output prdata, pready, pslverr, fast_request_n, normal_request_n, wakeUp);
	// Core end.
	modport core (output psel, penable, pwrite, paddr, pwdata,
		input prdata, pready, pslverr, fast_request_n, normal_request_n, wakeUp);
endinterface // ffpsm_if

// file: design/ffpsm_src_detect.sv
// Per-source active-level and active-edge detector.
// Assumes source inputs synchronous to core_clk.
`timescale 1ns/1ps
module ffpsm_src_detect #(
	parameter int N = 32
) (
	// Clock and reset.
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// Sources and their programming.
	input  wire logic [N-1:0] srcIn,
	input  wire logic [N-1:0] activeHigh,
	// Detected conditions.
	output logic      [N-1:0] activeLevel,
	output logic      [N-1:0] edgeHit
);
	import ffpsm_pkg::*;

	typedef struct packed {
		logic [N-1:0] lvl; // Active level as sampled.
		logic [N-1:0] hit; // One-cycle pulse on an active edge.
	} ffpsm_det_t;

	ffpsm_det_t s_ff;    // Registered state.
	ffpsm_det_t nxt_s;   // Next state.
	logic [N-1:0] actNow; // Level translated to active-high.

	////////////////////////////////////////////////////////////////////////
	// Translate each source to active-high.
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gActive
			assign actNow[g] = srcIn[g] ~^ activeHigh[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// An edge is an active level that was inactive on the prior sample.
	always_comb begin
		nxt_s.lvl = actNow;
		nxt_s.hit = actNow & ~s_ff.lvl;
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign activeLevel = s_ff.lvl;
	assign edgeHit     = s_ff.hit;
endmodule // ffpsm_src_detect

// file: design/ffpsm_ctrl.sv
// Interrupt controller end: fast path, fast forcing, protect mode, spurious vector, general mask.
// Assumes the core end as register-bus master and sources synchronous to core_clk.
// Function
// - Fast vector read returns source-0 vector.
// - Fast vector read clears edge source 0.
// - Level fast source cleared by handler.
// - Unvectored fast handler reads fast vector first.
// - Forcing enable/disable writes update forcing status.
// - Forced source hidden from normal priority logic.
// - Active forced source asserts fast request.
// - Forcing leaves source-0 pending bit alone.
// - Forcing in use: fast read keeps source 0.
// - Software clears forced edge sources by command.
// - Normal vector read keeps forced sources.
// - Source 0 remains a fast request source.
// - Debug-protect bit enables protect mode.
// - Normal read: compute, return, record, push, acknowledge.
// - Protect read: compute, return, record only.
// - Protect reads alone change no context.
// - Handler writes vector register right after read.
// - Normal mode vector write does nothing.
// - Nothing pending returns spurious vector.
// - Spurious handler ends interrupt and returns.
// - General mask idles both request lines.
// - End-of-interrupt pops priority stack.
// - Enable bit 0 controls fast interrupt.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ffpsm_ctrl #(
	parameter int N  = ffpsm_pkg::NUM_SRC,
	parameter int SD = ffpsm_pkg::STACK_DEPTH
) (
	// Clock and reset.
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// Link to the core.
	ffpsm_if.device           bus,
	// Interrupt sources.
	input  wire logic [N-1:0] srcIn
);
	import ffpsm_pkg::*;

	localparam int SW = $clog2(N);       // Width of a source number.
	localparam int DW = $clog2(SD + 1);  // Width of the stack depth.

	typedef struct packed {
		logic [N-1:0][1:0]  srcType;  // Edge and polarity per source.
		logic [N-1:0][2:0]  srcPrio;  // Priority per source.
		logic [N-1:0][31:0] vec;      // Source vectors.
		logic [31:0]        spurVec;  // Spurious vector.
		logic [N-1:0]       mask;     // Enabled sources.
		logic [N-1:0]       force_;   // Forcing status.
		logic [N-1:0]       edgePend; // Sticky edge pending flags.
		logic               protect;  // Protect mode.
		logic               gmask;    // General mask.
		logic [SD-1:0][2:0] stkLvl;   // Stacked priority levels.
		logic [SD-1:0][SW-1:0] stkSrc; // Stacked source numbers.
		logic [DW-1:0]      depth;    // Stack fill.
		logic [SW-1:0]      curSrc;   // Current source number.
		logic [SW-1:0]      recSrc;   // Source recorded by a protect read.
		logic               recValid; // A protect read found a source.
		logic               pready;   // Bus answer.
		logic               pslverr;  // Bus error answer.
		logic [31:0]        prdata;   // Bus read data.
		logic               fastN;    // Fast request line.
		logic               normalN;  // Normal request line.
		logic               wake;     // Idle wake-up level.
	} ffpsm_ctrl_t;

	ffpsm_ctrl_t  s_ff;     // Registered state.
	ffpsm_ctrl_t  nxt_s;    // Next state.
	logic [N-1:0] actHigh;  // Polarity per source.
	logic [N-1:0] lvlAct;   // Active levels from the detector.
	logic [N-1:0] edgeHit;  // Active edges from the detector.
	logic [N-1:0] edgeMode; // Edge mode per source.
	logic [N-1:0] pend;     // Pending per source.

	////////////////////////////////////////////////////////////////////////
	// Source programming and detection.
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gType
			assign actHigh[g]  = s_ff.srcType[g][TYPE_HIGH_BIT];
			assign edgeMode[g] = s_ff.srcType[g][TYPE_EDGE_BIT];
			assign pend[g]     = edgeMode[g] ? s_ff.edgePend[g] : lvlAct[g];
		end
	endgenerate

	ffpsm_src_detect #(.N(N)) uDetect (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.srcIn       (srcIn),
		.activeHigh  (actHigh),
		.activeLevel (lvlAct),
		.edgeHit     (edgeHit)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: priority search, bus decode and side effects.
	always_comb begin
		logic [N-1:0]  cand;      // Normal candidates.
		logic [N-1:0]  clr;       // Edge flags cleared this cycle.
		logic [N-1:0]  setCmd;    // Edge flags set by command.
		logic          bestValid; // A candidate beats the current level.
		logic [SW-1:0] bestSrc;   // Winning source.
		logic [2:0]    bestPrio;  // Winning priority.
		logic [2:0]    curLvl;    // Current level.
		logic          access;    // Access phase awaiting our answer.
		logic          doPush;    // Push and acknowledge this cycle.
		logic [SW-1:0] pushSrc;   // Source to push.
		logic [N-1:0]  wd;        // Write data cut to source width.
		logic          forcing;   // Some source other than 0 is forced.
		logic          fastRaw;   // Fast request before the general mask.
		logic [SW-1:0] idx;       // Mode or vector index.
		nxt_s     = s_ff;
		clr       = '0;
		setCmd    = '0;
		bestValid = 1'b0;
		bestSrc   = '0;
		bestPrio  = 3'h0;
		doPush    = 1'b0;
		pushSrc   = '0;
		wd        = bus.pwdata[N-1:0];
		idx       = bus.paddr[SW+1:2];
		curLvl    = (s_ff.depth != '0) ? s_ff.stkLvl[s_ff.depth - 1'b1] : 3'h0;
		forcing   = |s_ff.force_[N-1:1];
		access    = bus.psel & bus.penable & ~s_ff.pready;
		// Source 0 and forced sources drive the fast line.
		fastRaw   = (pend[0] & s_ff.mask[0]) | (|(pend & s_ff.mask & s_ff.force_));
		// Forced sources are hidden from priority.
		cand      = pend & s_ff.mask & ~s_ff.force_;
		cand[0]   = 1'b0;
		for (int i = N - 1; i > 0; i--) begin
			if (cand[i] && (!bestValid || s_ff.srcPrio[i] >= bestPrio) &&
				(s_ff.depth == '0 || s_ff.srcPrio[i] > curLvl)) begin
				bestValid = 1'b1;
				bestSrc   = SW'(i);
				bestPrio  = s_ff.srcPrio[i];
			end
		end
		nxt_s.pready  = access;
		nxt_s.pslverr = 1'b0;
		if (access && !bus.pwrite) begin
			// Reads: answer the data of the addressed register.
			nxt_s.prdata = RST_WORD;
			if (bus.paddr[11:7] == OFS_MODE_BASE[11:7]) begin
				if (32'(idx) < N) begin
					nxt_s.prdata[MODE_PRIO_LSB +: 3] = s_ff.srcPrio[idx];
					nxt_s.prdata[MODE_TYPE_LSB +: 2] = s_ff.srcType[idx];
				end
			end else if (bus.paddr[11:7] == OFS_VECTOR_BASE[11:7]) begin
				if (32'(idx) < N) begin
					nxt_s.prdata = s_ff.vec[idx];
				end
			end else begin
				unique case (bus.paddr)
					OFS_NORMAL_VEC: begin
						if (bestValid) begin
							nxt_s.prdata = s_ff.vec[bestSrc];
							if (s_ff.protect) begin
								nxt_s.recSrc   = bestSrc;
								nxt_s.recValid = 1'b1;
							end else begin
								doPush  = 1'b1;
								pushSrc = bestSrc;
							end
						end else begin
							nxt_s.prdata   = s_ff.spurVec;
							nxt_s.recValid = 1'b0;
						end
					end
					OFS_FAST_VEC: begin
						nxt_s.prdata = s_ff.vec[0];
						// Edge source 0 cleared unless forcing.
						clr[0] = edgeMode[0] & ~forcing;
					end
					OFS_CUR_STATUS:  nxt_s.prdata[SW-1:0] = s_ff.curSrc;
					OFS_PENDING:     nxt_s.prdata[N-1:0] = pend;
					OFS_MASK:        nxt_s.prdata[N-1:0] = s_ff.mask;
					OFS_CORE_STATUS: begin
						nxt_s.prdata[CORE_FAST_BIT]   = ~s_ff.fastN;
						nxt_s.prdata[CORE_NORMAL_BIT] = ~s_ff.normalN;
					end
					OFS_SPURIOUS:    nxt_s.prdata = s_ff.spurVec;
					OFS_DEBUG_CTRL: begin
						nxt_s.prdata[DBG_PROTECT_BIT] = s_ff.protect;
						nxt_s.prdata[DBG_GMASK_BIT]   = s_ff.gmask;
					end
					OFS_FORCE_STAT:  nxt_s.prdata[N-1:0] = s_ff.force_;
					default:         nxt_s.pslverr = 1'b1;
				endcase
			end
		end else if (access) begin
			// Writes: update registers and issue commands.
			if (bus.paddr[11:7] == OFS_MODE_BASE[11:7]) begin
				if (32'(idx) < N) begin
					nxt_s.srcPrio[idx] = bus.pwdata[MODE_PRIO_LSB +: 3];
					nxt_s.srcType[idx] = bus.pwdata[MODE_TYPE_LSB +: 2];
				end
			end else if (bus.paddr[11:7] == OFS_VECTOR_BASE[11:7]) begin
				if (32'(idx) < N) begin
					nxt_s.vec[idx] = bus.pwdata;
				end
			end else begin
				unique case (bus.paddr)
					OFS_NORMAL_VEC: begin
						// Only protect mode acts on the write.
						if (s_ff.protect && s_ff.recValid) begin
							doPush         = 1'b1;
							pushSrc        = s_ff.recSrc;
							nxt_s.recValid = 1'b0;
						end
					end
					// Bit 0 enables or disables the fast source.
					OFS_ENABLE_CMD:  nxt_s.mask = s_ff.mask | wd;
					OFS_DISABLE_CMD: nxt_s.mask = s_ff.mask & ~wd;
					// Edge flags cleared at once for every source set in the write data, except a source with a new edge in the same cycle.
					OFS_CLEAR_CMD:   clr = wd;
					OFS_SET_CMD:     setCmd = wd;
					OFS_END_OF_INT: begin
						// Pop the stack and restore previous level.
						if (s_ff.depth != '0) begin
							nxt_s.depth = s_ff.depth - 1'b1;
							if (s_ff.depth > DW'(1)) begin
								nxt_s.curSrc = s_ff.stkSrc[s_ff.depth - DW'(2)];
							end
						end
					end
					OFS_SPURIOUS:    nxt_s.spurVec = bus.pwdata;
					OFS_DEBUG_CTRL: begin
						nxt_s.protect = bus.pwdata[DBG_PROTECT_BIT];
						nxt_s.gmask   = bus.pwdata[DBG_GMASK_BIT];
					end
					// Forcing enable and disable update status.
					OFS_FORCE_EN:    nxt_s.force_ = s_ff.force_ | {wd[N-1:1], 1'b0};
					OFS_FORCE_DIS:   nxt_s.force_ = s_ff.force_ & ~{wd[N-1:1], 1'b0};
					default:         nxt_s.pslverr = 1'b1;
				endcase
			end
		end
		// Push level, record source, acknowledge edge source.
		if (doPush) begin
			if (32'(s_ff.depth) < SD) begin
				nxt_s.stkLvl[s_ff.depth] = s_ff.srcPrio[pushSrc];
				nxt_s.stkSrc[s_ff.depth] = pushSrc;
				nxt_s.depth              = s_ff.depth + 1'b1;
			end
			nxt_s.curSrc  = pushSrc;
			// A forced source is never acknowledged here.
			clr[pushSrc]  = edgeMode[pushSrc] & ~s_ff.force_[pushSrc];
		end
		// Edge flags: a new edge wins over a clear in the same cycle.
		// Forcing never touches pending.
		nxt_s.edgePend = (s_ff.edgePend & ~clr) | edgeHit | (setCmd & edgeMode);
		// General mask idles both lines, wake-up still works.
		nxt_s.fastN   = ~(fastRaw & ~s_ff.gmask);
		nxt_s.normalN = ~(bestValid & ~s_ff.gmask);
		nxt_s.wake    = fastRaw | bestValid;
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			// Forcing, protect and mask all cleared.
			s_ff         <= '0;
			s_ff.fastN   <= 1'b1;
			s_ff.normalN <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register.
	assign bus.prdata           = s_ff.prdata;
	assign bus.pready           = s_ff.pready;
	assign bus.pslverr          = s_ff.pslverr;
	assign bus.fast_request_n   = s_ff.fastN;
	assign bus.normal_request_n = s_ff.normalN;
	assign bus.wakeUp           = s_ff.wake;
endmodule // ffpsm_ctrl

// file: design/ffpsm_core.sv
// Core end: register-bus master with optional automatic interrupt service steps.
// Assumes the controller end on the other side of ffpsm_if and one shared clock.
`timescale 1ns/1ps
module ffpsm_core (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Link to the controller.
	ffpsm_if.core            bus,
	// Command port.
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [11:0] cmdAddr,
	input  wire logic [31:0] cmdWdata,
	output logic             cmdReady,
	// Answer port.
	output logic             rspValid,
	output logic [31:0]      rspRdata,
	output logic             rspErr,
	// Service options and request levels.
	input  wire logic        autoService,
	output logic             fastRequest,
	output logic             normalRequest,
	output logic             wakeRequest
);
	import ffpsm_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_ACCESS = 2'b11
	} ffpsm_state_t;

	typedef struct packed {
		ffpsm_state_t st;       // Transfer state.
		logic         psel;     // Bus select.
		logic         penable;  // Bus enable.
		logic         pwrite;   // Bus direction.
		logic [11:0]  paddr;    // Bus address.
		logic [31:0]  pwdata;   // Bus write data.
		logic         follow;   // Vector write owed after a normal vector read.
		logic         armed;    // Fast line seen idle since last auto read.
		logic         cmdReady; // Command port ready.
		logic         rspValid; // Answer pulse.
		logic [31:0]  rspRdata; // Answer data.
		logic         rspErr;   // Answer error.
		logic         fastReq;  // Fast request level.
		logic         normReq;  // Normal request level.
		logic         wake;     // Wake-up level.
	} ffpsm_core_t;

	ffpsm_core_t s_ff;  // Registered state.
	ffpsm_core_t nxt_s; // Next state.

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: pick a transfer, run setup and access phases.
	always_comb begin
		logic autoFast; // Automatic fast vector read wanted.
		autoFast = autoService & s_ff.fastReq & s_ff.armed;
		nxt_s         = s_ff;
		nxt_s.fastReq = ~bus.fast_request_n;
		nxt_s.normReq = ~bus.normal_request_n;
		nxt_s.wake    = bus.wakeUp;
		nxt_s.rspValid = 1'b0;
		if (!s_ff.fastReq) begin
			nxt_s.armed = 1'b1;
		end
		unique case (s_ff.st)
			ST_IDLE: begin
				if (s_ff.follow) begin
					// Write the vector register right after reading it.
					nxt_s.pwrite = 1'b1;
					nxt_s.paddr  = OFS_NORMAL_VEC;
					nxt_s.pwdata = RST_WORD;
					nxt_s.follow = 1'b0;
					nxt_s.psel   = 1'b1;
					nxt_s.st     = ST_SETUP;
				end else if (autoFast) begin
					// Fast vector read first on a fast request.
					nxt_s.pwrite = 1'b0;
					nxt_s.paddr  = OFS_FAST_VEC;
					nxt_s.armed  = 1'b0;
					nxt_s.psel   = 1'b1;
					nxt_s.st     = ST_SETUP;
				end else if (cmdValid && s_ff.cmdReady) begin
					// Take the command from the user side.
					nxt_s.pwrite = cmdWrite;
					nxt_s.paddr  = cmdAddr;
					nxt_s.pwdata = cmdWdata;
					nxt_s.psel   = 1'b1;
					nxt_s.st     = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Setup cycle done, enter the access phase.
				nxt_s.penable = 1'b1;
				nxt_s.st      = ST_ACCESS;
			end
			ST_ACCESS: begin
				// Hold the request until the controller answers.
				if (bus.pready) begin
					nxt_s.psel     = 1'b0;
					nxt_s.penable  = 1'b0;
					nxt_s.rspValid = 1'b1;
					nxt_s.rspRdata = bus.prdata;
					nxt_s.rspErr   = bus.pslverr;
					nxt_s.st       = ST_IDLE;
					nxt_s.follow   = autoService & ~s_ff.pwrite & (s_ff.paddr == OFS_NORMAL_VEC);
				end
			end
			default: begin
				nxt_s.st = ST_IDLE;
			end
		endcase
		nxt_s.cmdReady = (nxt_s.st == ST_IDLE) & ~nxt_s.follow &
			~(autoService & nxt_s.fastReq & nxt_s.armed);
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register.
	assign bus.psel      = s_ff.psel;
	assign bus.penable   = s_ff.penable;
	assign bus.pwrite    = s_ff.pwrite;
	assign bus.paddr     = s_ff.paddr;
	assign bus.pwdata    = s_ff.pwdata;
	assign cmdReady      = s_ff.cmdReady;
	assign rspValid      = s_ff.rspValid;
	assign rspRdata      = s_ff.rspRdata;
	assign rspErr        = s_ff.rspErr;
	assign fastRequest   = s_ff.fastReq;
	assign normalRequest = s_ff.normReq;
	assign wakeRequest   = s_ff.wake;
endmodule // ffpsm_core

// file: bench/ffpsm_properties.sv
// Checker for the register bus and request lines between the controller and core ends.
// Assumes one clock, a synchronous active-high reset and the offsets of the shared package.
`timescale 1ns/1ps
module ffpsm_properties (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Register bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Request lines.
	input wire logic        fast_request_n,
	input wire logic        normal_request_n,
	input wire logic        wakeUp
);
	import ffpsm_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [31:0] vecZero_ff;   // Shadow of the source 0 vector.
	logic [31:0] forceStat_ff; // Shadow of the forcing status.
	logic [1:0]  dbgCtrl_ff;   // Shadow of the debug control bits.
	logic        rdDone;       // A read answer is on the bus.
	assign rdDone = psel && penable && pready && !pwrite;
	////////////////////////////////////////////////////////////
	// Shadows change at the edge where the controller acts on a write.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			vecZero_ff <= RST_WORD;
			forceStat_ff <= RST_WORD;
			dbgCtrl_ff <= 2'h0;
		end else if (psel && penable && !pready && pwrite) begin
			if (paddr == OFS_VECTOR_BASE) vecZero_ff <= pwdata;
			if (paddr == OFS_FORCE_EN) forceStat_ff <= forceStat_ff | (pwdata & 32'hffff_fffe);
			if (paddr == OFS_FORCE_DIS) forceStat_ff <= forceStat_ff & ~pwdata;
			if (paddr == OFS_DEBUG_CTRL) dbgCtrl_ff <= pwdata[1:0];
		end
	end
	////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		!pready ##1 (pready && penable);
	endsequence
	chk_one_wait: assert property (s_setup ##1 penable |-> s_answer)
		else $error("access phase not two cycles");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_unmapped_err: assert property (psel && pready && paddr == 12'h118 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_fast_vec: assert property (rdDone && paddr == OFS_FAST_VEC |-> prdata == vecZero_ff)
		else $error("fast vector differs from source 0 vector");
	chk_force_stat: assert property (rdDone && paddr == OFS_FORCE_STAT |-> prdata == forceStat_ff)
		else $error("forcing status wrong");
	chk_dbg_read: assert property (rdDone && paddr == OFS_DEBUG_CTRL |-> prdata == {30'h0, dbgCtrl_ff})
		else $error("debug control readback wrong");
	chk_gmask_idle: assert property (dbgCtrl_ff[1] && $past(dbgCtrl_ff[1]) |-> fast_request_n && normal_request_n)
		else $error("request line active under general mask");
	chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=> fast_request_n && normal_request_n && !wakeUp)
		else $error("request lines active after reset");
endmodule // ffpsm_properties

// file: bench/fast_forcing_protect_spurious_mask_test.sv
// Self-checking bench: controller and core ends joined by their interface.
// Assumes registers are reached only through the core end, by its command port or its automatic service reads.
`timescale 1ns/1ps
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin numErrors++; $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module fast_forcing_protect_spurious_mask_test;
	import ffpsm_pkg::*;
	logic        core_clk;
	logic        sys_rst;
	logic [31:0] srcIn;       // Sources, active low; 0 and 3 set to falling edge here.
	logic        cmdValid;
	logic        cmdWrite;
	logic [11:0] cmdAddr;
	logic [31:0] cmdWdata;
	logic        cmdReady;
	logic        rspValid;
	logic [31:0] rspRdata;
	logic        rspErr;
	logic        autoService;
	logic        fastRequest;
	logic        normalRequest;
	logic        wakeRequest;
	logic [31:0] rd;          // Last read data.
	logic        err;         // Last error flag.
	int          numErrors;
	int          totalChecks;
	ffpsm_if bus ();
	ffpsm_ctrl i_ffpsm_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .srcIn(srcIn));
	ffpsm_core i_ffpsm_core (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspRdata(rspRdata), .rspErr(rspErr), .autoService(autoService), .fastRequest(fastRequest),
		.normalRequest(normalRequest), .wakeRequest(wakeRequest));
	ffpsm_properties i_ffpsm_properties (.core_clk(core_clk), .sys_rst(sys_rst), .psel(bus.psel),
		.penable(bus.penable), .pwrite(bus.pwrite), .paddr(bus.paddr), .pwdata(bus.pwdata), .prdata(bus.prdata),
		.pready(bus.pready), .pslverr(bus.pslverr), .fast_request_n(bus.fast_request_n),
		.normal_request_n(bus.normal_request_n), .wakeUp(bus.wakeUp));
	////////////////////////////////////////////////////////////
	// Clock of 50 ns.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// One command: held until taken, then the answer, then time for the lines to settle.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdAddr <= a;
		cmdWdata <= d;
		n = 0;
		do begin @(negedge core_clk); n++; end while (cmdReady !== 1'b1 && n < 50);
		@(posedge core_clk);
		cmdValid <= 1'b0;
		do begin @(negedge core_clk); n++; end while (rspValid !== 1'b1 && n < 100);
		if (n >= 100) numErrors++;
		rd = rspRdata;
		err = rspErr;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Source change at an edge, then time for the request lines.
	task automatic drive(input int i, input logic v);
		@(posedge core_clk);
		srcIn[i] <= v;
		repeat (5) @(negedge core_clk);
	endtask
	task automatic done(input string s);
		$display("test %s finished, checks %0d", s, totalChecks);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of under four hundred cycles.
	initial begin
		repeat (8000) @(posedge core_clk);
		numErrors++;
		results();
	end
	////////////////////////////////////////////////////////////
	initial begin
		srcIn = 32'hffff_ffff;
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdAddr = 12'h000;
		cmdWdata = 32'h0;
		autoService = 1'b0;
		numErrors = 0;
		totalChecks = 0;
		sys_rst = 1'b1;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdchk(OFS_FORCE_STAT, 32'h0);
		rdchk(OFS_DEBUG_CTRL, 32'h0);
		`CHK({fastRequest, normalRequest}, 2'h0)
		done("reset");
		xfer(1'b1, OFS_SPURIOUS, 32'h5a5a_0000);
		xfer(1'b1, OFS_VECTOR_BASE, 32'hcafe_0000);
		xfer(1'b1, OFS_VECTOR_BASE + 12'h00c, 32'hbeef_0300);
		xfer(1'b1, OFS_MODE_BASE, 32'h20);
		xfer(1'b1, OFS_MODE_BASE + 12'h00c, 32'h23);
		xfer(1'b1, OFS_ENABLE_CMD, 32'h9);
		rdchk(OFS_MASK, 32'h9);
		drive(0, 1'b0);
		`CHK(fastRequest, 1'b1)
		rdchk(OFS_FAST_VEC, 32'hcafe_0000);
		drive(0, 1'b1);
		`CHK(fastRequest, 1'b0)
		done("fast path");
		xfer(1'b1, OFS_FORCE_EN, 32'h9);
		rdchk(OFS_FORCE_STAT, 32'h8);
		drive(3, 1'b0);
		`CHK({fastRequest, normalRequest}, 2'h2)
		rdchk(OFS_PENDING, 32'h8);
		rdchk(OFS_FAST_VEC, 32'hcafe_0000);
		`CHK(fastRequest, 1'b1)
		rdchk(OFS_NORMAL_VEC, 32'h5a5a_0000);
		xfer(1'b1, OFS_END_OF_INT, 32'h0);
		rdchk(OFS_PENDING, 32'h8);
		xfer(1'b1, OFS_CLEAR_CMD, 32'h8);
		rdchk(OFS_PENDING, 32'h0);
		xfer(1'b1, OFS_FORCE_DIS, 32'h8);
		rdchk(OFS_FORCE_STAT, 32'h0);
		drive(3, 1'b1);
		`CHK(fastRequest, 1'b0)
		done("forcing");
		xfer(1'b1, OFS_DEBUG_CTRL, 32'h1);
		rdchk(OFS_DEBUG_CTRL, 32'h1);
		drive(3, 1'b0);
		rdchk(OFS_NORMAL_VEC, 32'hbeef_0300);
		rdchk(OFS_NORMAL_VEC, 32'hbeef_0300);
		`CHK(normalRequest, 1'b1)
		xfer(1'b1, OFS_NORMAL_VEC, 32'h0);
		rdchk(OFS_CUR_STATUS, 32'h3);
		`CHK(normalRequest, 1'b0)
		xfer(1'b1, OFS_END_OF_INT, 32'h0);
		drive(3, 1'b1);
		done("protect");
		xfer(1'b1, OFS_DEBUG_CTRL, 32'h0);
		drive(3, 1'b0);
		rdchk(OFS_NORMAL_VEC, 32'hbeef_0300);
		`CHK(normalRequest, 1'b0)
		rdchk(OFS_CUR_STATUS, 32'h3);
		xfer(1'b1, OFS_END_OF_INT, 32'h0);
		drive(3, 1'b1);
		drive(3, 1'b0);
		xfer(1'b1, OFS_NORMAL_VEC, 32'h0);
		`CHK(normalRequest, 1'b1)
		xfer(1'b1, OFS_DEBUG_CTRL, 32'h2);
		`CHK({normalRequest, wakeRequest}, 2'h1)
		xfer(1'b1, OFS_DEBUG_CTRL, 32'h0);
		`CHK(normalRequest, 1'b1)
		done("normal and mask");
		xfer(1'b0, 12'h118, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		@(posedge core_clk);
		autoService <= 1'b1;
		drive(0, 1'b0);
		repeat (20) @(negedge core_clk);
		`CHK(fastRequest, 1'b0)
		done("unmapped and auto");
		results();
	end
endmodule // fast_forcing_protect_spurious_mask_test
